/* File: include/rtcio_pkg.sv */
/*
  constants for the remote ttl control and channel i/o block: pin indices,
  register offsets, reset values, status field positions, priming count and
  the state type. assumes nothing beyond a systemverilog compiler.
*/
package rtcio_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned NUM_REMOTE = 12;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned GS_W = 10;

  // ************************************************************
  // remote input positions inside the synchronised vector
  // ************************************************************
  localparam int unsigned RI_IG1 = 0;
  localparam int unsigned RI_IG2 = 1;
  localparam int unsigned RI_DEGAS = 2;
  localparam int unsigned RI_LOCK = 3;
  localparam int unsigned RI_KEY = 4;
  localparam int unsigned RI_PG1 = 5;
  localparam int unsigned RI_PG2 = 6;
  localparam int unsigned RI_LOG = 7;
  localparam int unsigned RI_REN = 8;
  localparam int unsigned RI_FIL1 = 9;
  localparam int unsigned RI_FIL2 = 10;
  localparam int unsigned RI_PANEL = 11;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CHAN_MANUAL = 8'h00;
  localparam logic [7:0] ADDR_CHAN_AUTO = 8'h04;
  localparam logic [7:0] ADDR_CHAN_POL = 8'h08;
  localparam logic [7:0] ADDR_REMOTE_LVL = 8'h0C;
  localparam logic [7:0] ADDR_GAUGE_STAT = 8'h10;
  localparam logic [7:0] ADDR_CHAN_STAT = 8'h14;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_CHAN_MANUAL = 8'h00;
  localparam logic [7:0] RST_CHAN_AUTO = 8'h00;
  localparam logic [7:0] RST_CHAN_POL = 8'h00;
  localparam logic [11:0] RST_REMOTE_IDLE = 12'hFFF;
  localparam logic [7:0] RST_CHAN_IDLE = 8'hFF;
  localparam logic [7:0] RST_OUT_N = 8'hFF;
  localparam logic [7:0] RST_RELAY = 8'h00;
  localparam logic RST_PIRANI_ON = 1'b1;

  // ************************************************************
  // gauge status register fields
  // ************************************************************
  localparam int unsigned GS_IG1 = 0;
  localparam int unsigned GS_IG2 = 1;
  localparam int unsigned GS_DEGAS = 2;
  localparam int unsigned GS_FIL1 = 3;
  localparam int unsigned GS_FIL2 = 4;
  localparam int unsigned GS_PG1 = 5;
  localparam int unsigned GS_PG2 = 6;
  localparam int unsigned GS_KEY_IGN = 7;
  localparam int unsigned GS_PANEL_IGN = 8;
  localparam int unsigned GS_RUN = 9;

  // ************************************************************
  // priming: one less than the cycles after reset release before edges count
  // ************************************************************
  localparam logic [2:0] PRIME_CYCLES = 3'h5;

  typedef enum logic [1:0] {
    ST_PRIME = 2'b01,
    ST_RUN = 2'b10
  } rtcio_state_e;

endpackage

/* File: src/rtcio_sync.sv */
/*
  three-stage synchroniser with agreement filter for a bus of independent
  asynchronous lines. assumes a single clock and an already synchronised
  active-low reset.
*/
`timescale 1ns/1ns
module rtcio_sync #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  // ************************************************************
  // per-line stages
  // ************************************************************
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_line
      // stage1 feeds only stage2; level moves when stage2 and stage3 agree
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1_reg[gi] <= RESET_VAL[gi];
          stage2_reg[gi] <= RESET_VAL[gi];
          stage3_reg[gi] <= RESET_VAL[gi];
          level_out[gi] <= RESET_VAL[gi];
        end
        else
        begin
          stage1_reg[gi] <= async_in[gi];
          stage2_reg[gi] <= stage1_reg[gi];
          stage3_reg[gi] <= stage2_reg[gi];
          if (stage2_reg[gi] == stage3_reg[gi])
            level_out[gi] <= stage3_reg[gi]; // single-cycle glitches never pass
        end
      end
    end
  endgenerate

endmodule

/* File: src/rtcio_top.sv */
/*
  remote ttl control inputs and process channel ttl i/o of a vacuum gauge
  controller. turns remote pin edges and levels into gauge control states,
  drives eight active-low channel outputs and relay drives, and offers a
  small register port. assumes opto-isolated pins arriving asynchronously
  and a gauge controller that acts on the state outputs.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
module rtcio_top #(
  parameter int unsigned NUM_CHAN = rtcio_pkg::NUM_CHAN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gauge_one_emission_request,
  input wire logic gauge_two_emission_request,
  input wire logic degas_request,
  input wire logic emission_lockout,
  input wire logic gauge_keypad_disable,
  input wire logic pirani_one_power_input,
  input wire logic pirani_two_power_input,
  input wire logic log_clear_request,
  input wire logic remote_gauge_enable,
  input wire logic filament_one_select,
  input wire logic filament_two_select,
  input wire logic panel_disable_n,
  input wire logic [NUM_CHAN-1:0] channel_in,
  input wire logic [rtcio_pkg::ADDR_W-1:0] addr,
  input wire logic [rtcio_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [rtcio_pkg::DATA_W-1:0] rd_data,
  output logic [NUM_CHAN-1:0] channel_out_n,
  output logic [NUM_CHAN-1:0] relay_drive,
  output logic gauge_one_emission_on,
  output logic gauge_two_emission_on,
  output logic degas_on,
  output logic filament_one_on,
  output logic filament_two_on,
  output logic pirani_one_on,
  output logic pirani_two_on,
  output logic log_clear_pulse,
  output logic keypad_ignore,
  output logic panel_ignore
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_n;

  // async assert, release through two flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [rtcio_pkg::NUM_REMOTE-1:0] remote_raw;
  logic [rtcio_pkg::NUM_REMOTE-1:0] remote_lvl;
  logic [NUM_CHAN-1:0] chan_lvl;

  // twelve remote lines gathered into one vector
  assign remote_raw = {panel_disable_n, filament_two_select, filament_one_select,
                       remote_gauge_enable, log_clear_request, pirani_two_power_input,
                       pirani_one_power_input, gauge_keypad_disable, emission_lockout,
                       degas_request, gauge_two_emission_request,
                       gauge_one_emission_request};

  rtcio_sync #(
    .WIDTH(rtcio_pkg::NUM_REMOTE),
    .RESET_VAL(rtcio_pkg::RST_REMOTE_IDLE)
  ) u_remote_sync (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .async_in(remote_raw),
    .level_out(remote_lvl)
  );

  rtcio_sync #(
    .WIDTH(NUM_CHAN),
    .RESET_VAL(rtcio_pkg::RST_CHAN_IDLE)
  ) u_chan_sync (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .async_in(channel_in),
    .level_out(chan_lvl)
  );

  // ************************************************************
  // priming and edge detection
  // ************************************************************
  rtcio_pkg::rtcio_state_e state_reg;
  logic [2:0] prime_cnt_reg;
  logic [rtcio_pkg::NUM_REMOTE-1:0] prev_lvl_reg;
  logic [rtcio_pkg::NUM_REMOTE-1:0] fall_v;
  logic [rtcio_pkg::NUM_REMOTE-1:0] rise_v;
  logic run;

  // wait until the synchroniser has flushed its reset value
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg <= rtcio_pkg::ST_PRIME;
      prime_cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        rtcio_pkg::ST_PRIME:
        begin
          prime_cnt_reg <= prime_cnt_reg + 3'h1;
          if (prime_cnt_reg == rtcio_pkg::PRIME_CYCLES)
            state_reg <= rtcio_pkg::ST_RUN;
        end
        rtcio_pkg::ST_RUN:
          state_reg <= rtcio_pkg::ST_RUN;
        default:
          state_reg <= rtcio_pkg::ST_PRIME;
      endcase
    end
  end

  // history always tracks, so the first edge after priming is genuine
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      prev_lvl_reg <= rtcio_pkg::RST_REMOTE_IDLE;
    else
      prev_lvl_reg <= remote_lvl;
  end

  assign run = (state_reg == rtcio_pkg::ST_RUN);
  assign fall_v = prev_lvl_reg & ~remote_lvl & {rtcio_pkg::NUM_REMOTE{run}};
  assign rise_v = ~prev_lvl_reg & remote_lvl & {rtcio_pkg::NUM_REMOTE{run}};

  // ************************************************************
  // gauge control states
  // ************************************************************
  logic remote_blocked;
  logic lockout_clear;

  assign remote_blocked = remote_lvl[rtcio_pkg::RI_REN];
  assign lockout_clear = remote_lvl[rtcio_pkg::RI_LOCK];

  // emission: lockout is a level and outranks any request edge
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gauge_one_emission_on <= 1'b0;
      gauge_two_emission_on <= 1'b0;
    end
    else
    begin
      if (!lockout_clear)
        gauge_one_emission_on <= 1'b0;
      else if (!remote_blocked && fall_v[rtcio_pkg::RI_IG1])
        gauge_one_emission_on <= 1'b1;
      else if (!remote_blocked && rise_v[rtcio_pkg::RI_IG1])
        gauge_one_emission_on <= 1'b0;
      if (!lockout_clear)
        gauge_two_emission_on <= 1'b0;
      else if (!remote_blocked && fall_v[rtcio_pkg::RI_IG2])
        gauge_two_emission_on <= 1'b1;
      else if (!remote_blocked && rise_v[rtcio_pkg::RI_IG2])
        gauge_two_emission_on <= 1'b0;
    end
  end

  // degas and filaments, all gated by remote enable
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      degas_on <= 1'b0;
      filament_one_on <= 1'b0;
      filament_two_on <= 1'b0;
    end
    else if (!remote_blocked)
    begin
      if (fall_v[rtcio_pkg::RI_DEGAS])
        degas_on <= 1'b1;
      else if (rise_v[rtcio_pkg::RI_DEGAS])
        degas_on <= 1'b0;
      if (fall_v[rtcio_pkg::RI_FIL1])
        filament_one_on <= 1'b1;
      else if (rise_v[rtcio_pkg::RI_FIL1])
        filament_one_on <= 1'b0;
      if (fall_v[rtcio_pkg::RI_FIL2])
        filament_two_on <= 1'b1;
      else if (rise_v[rtcio_pkg::RI_FIL2])
        filament_two_on <= 1'b0;
    end
  end

  // pirani power is inverted: a falling edge powers the gauge down
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pirani_one_on <= rtcio_pkg::RST_PIRANI_ON;
      pirani_two_on <= rtcio_pkg::RST_PIRANI_ON;
    end
    else
    begin
      if (fall_v[rtcio_pkg::RI_PG1])
        pirani_one_on <= 1'b0;
      else if (rise_v[rtcio_pkg::RI_PG1])
        pirani_one_on <= 1'b1;
      if (fall_v[rtcio_pkg::RI_PG2])
        pirani_two_on <= 1'b0;
      else if (rise_v[rtcio_pkg::RI_PG2])
        pirani_two_on <= 1'b1;
    end
  end

  // log clear is a one-cycle command; level disables follow the pins
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      log_clear_pulse <= 1'b0;
      keypad_ignore <= 1'b0;
      panel_ignore <= 1'b0;
    end
    else
    begin
      log_clear_pulse <= fall_v[rtcio_pkg::RI_LOG];
      keypad_ignore <= ~remote_lvl[rtcio_pkg::RI_KEY];
      panel_ignore <= ~remote_lvl[rtcio_pkg::RI_PANEL];
    end
  end

  // ************************************************************
  // process channels
  // ************************************************************
  logic [NUM_CHAN-1:0] chan_manual_reg;
  logic [NUM_CHAN-1:0] chan_auto_reg;
  logic [NUM_CHAN-1:0] chan_pol_reg;
  logic [NUM_CHAN-1:0] chan_act;

  genvar ci;
  generate
    for (ci = 0; ci < NUM_CHAN; ci = ci + 1)
    begin : g_chan
      // auto channels follow their input at the chosen polarity
      assign chan_act[ci] = run && (chan_auto_reg[ci] ?
                            (chan_lvl[ci] == chan_pol_reg[ci]) : chan_manual_reg[ci]);

      // output and relay come from the same term so they never disagree
      always_ff @(posedge ref_clk or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
        begin
          channel_out_n[ci] <= rtcio_pkg::RST_OUT_N[ci];
          relay_drive[ci] <= rtcio_pkg::RST_RELAY[ci];
        end
        else
        begin
          channel_out_n[ci] <= ~chan_act[ci];
          relay_drive[ci] <= chan_act[ci];
        end
      end
    end
  endgenerate

  // ************************************************************
  // register port
  // ************************************************************
  logic [rtcio_pkg::GS_W-1:0] gauge_stat;

  assign gauge_stat = {run, panel_ignore, keypad_ignore, pirani_two_on, pirani_one_on,
                       filament_two_on, filament_one_on, degas_on,
                       gauge_two_emission_on, gauge_one_emission_on};

  // writes: unmapped offsets are dropped
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      chan_manual_reg <= rtcio_pkg::RST_CHAN_MANUAL;
      chan_auto_reg <= rtcio_pkg::RST_CHAN_AUTO;
      chan_pol_reg <= rtcio_pkg::RST_CHAN_POL;
    end
    else if (wr_en)
    begin
      if (addr == rtcio_pkg::ADDR_CHAN_MANUAL)
        chan_manual_reg <= wr_data[NUM_CHAN-1:0];
      else if (addr == rtcio_pkg::ADDR_CHAN_AUTO)
        chan_auto_reg <= wr_data[NUM_CHAN-1:0];
      else if (addr == rtcio_pkg::ADDR_CHAN_POL)
        chan_pol_reg <= wr_data[NUM_CHAN-1:0];
    end
  end

  // read data stands one cycle only; zero elsewhere and for unmapped offsets
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_data <= '0;
    else if (!rd_en)
      rd_data <= '0;
    else if (addr == rtcio_pkg::ADDR_CHAN_MANUAL)
      rd_data <= rtcio_pkg::DATA_W'(chan_manual_reg);
    else if (addr == rtcio_pkg::ADDR_CHAN_AUTO)
      rd_data <= rtcio_pkg::DATA_W'(chan_auto_reg);
    else if (addr == rtcio_pkg::ADDR_CHAN_POL)
      rd_data <= rtcio_pkg::DATA_W'(chan_pol_reg);
    else if (addr == rtcio_pkg::ADDR_REMOTE_LVL)
      rd_data <= rtcio_pkg::DATA_W'(remote_lvl);
    else if (addr == rtcio_pkg::ADDR_GAUGE_STAT)
      rd_data <= rtcio_pkg::DATA_W'(gauge_stat);
    else if (addr == rtcio_pkg::ADDR_CHAN_STAT)
      rd_data <= rtcio_pkg::DATA_W'({chan_lvl, ~channel_out_n});
    else
      rd_data <= '0;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_ig1_fall;
    fall_v[rtcio_pkg::RI_IG1] && !remote_blocked && lockout_clear;
  endsequence
  sequence s_ig1_rise;
    rise_v[rtcio_pkg::RI_IG1] && !remote_blocked && lockout_clear;
  endsequence

  a_edge_sense: assert property (fall_v[rtcio_pkg::RI_IG1] |->
    $past(remote_lvl[rtcio_pkg::RI_IG1]) && !remote_lvl[rtcio_pkg::RI_IG1])
    else $error("falling edge flagged without high-to-low change");
  a_gauge_one_emission_request: assert property (s_ig1_fall |=> gauge_one_emission_on)
    else $error("gauge one emission not on after falling request");
  a_ig1_off: assert property (s_ig1_rise |=> !gauge_one_emission_on)
    else $error("gauge one emission not off after rising request");
  a_gauge_two_emission_request: assert property (fall_v[rtcio_pkg::RI_IG2] && !remote_blocked
    && lockout_clear |=> gauge_two_emission_on)
    else $error("gauge two emission not on after falling request");
  a_degas_cmd: assert property (rise_v[rtcio_pkg::RI_DEGAS] && !remote_blocked
    |=> !degas_on)
    else $error("degas still on after rising request");
  a_lockout_hold: assert property (!lockout_clear [*2] |->
    !gauge_one_emission_on && !gauge_two_emission_on)
    else $error("emission on while lockout held low");
  a_keypad_level: assert property (##1 keypad_ignore ==
    !$past(remote_lvl[rtcio_pkg::RI_KEY]))
    else $error("keypad ignore does not follow disable level");
  a_pirani_one: assert property (fall_v[rtcio_pkg::RI_PG1] |=> !pirani_one_on)
    else $error("pirani one still on after falling edge");
  a_pirani_two: assert property (rise_v[rtcio_pkg::RI_PG2] |=> pirani_two_on)
    else $error("pirani two not on after rising edge");
  a_log_clear: assert property (log_clear_pulse |->
    $past(fall_v[rtcio_pkg::RI_LOG]) ##1 !log_clear_pulse)
    else $error("log clear pulse without falling edge or too long");
  a_remote_block: assert property (remote_blocked && lockout_clear |=>
    $stable(gauge_one_emission_on) && $stable(degas_on) && $stable(filament_one_on))
    else $error("request acted on while remote enable high");
  a_fil_two: assert property (fall_v[rtcio_pkg::RI_FIL2] && !remote_blocked
    |=> filament_two_on)
    else $error("filament two not on after falling edge");
  a_panel_level: assert property (!remote_lvl[rtcio_pkg::RI_PANEL] |=> panel_ignore)
    else $error("panel not ignored while disable low");
  a_chan_out: assert property (##1 channel_out_n == ~$past(chan_act))
    else $error("channel output does not mirror channel state");
  a_relay_match: assert property (relay_drive == ~channel_out_n)
    else $error("relay drive disagrees with channel output");
  a_prime_quiet: assert property (!run |-> fall_v == '0 && rise_v == '0
    ##1 channel_out_n == rtcio_pkg::RST_OUT_N)
    else $error("activity before input history primed");

endmodule

/* File: verification/rtcio_user_equip.sv */
/*
  model of the user equipment on the ttl connector: drives the twelve remote
  pins and the eight channel inputs.
  assumes the bench calls its tasks and that ref_clk runs freely.
*/
`timescale 1ns/1ns
module rtcio_user_equip (
  input wire logic ref_clk,
  output logic [11:0] remote_pins,
  output logic [7:0] channel_pins
);
  // idle lines sit high through the opto pull-ups
  initial
  begin
    remote_pins = 12'hFFF;
    channel_pins = 8'hFF;
  end

  // one clean full swing, then held well past the glitch filter
  task automatic drive_remote(input int idx, input logic val);
    @(posedge ref_clk);
    remote_pins[idx] <= val;
    repeat (8) @(posedge ref_clk);
  endtask

  // the user picks the level; its meaning comes from the polarity setting
  task automatic drive_chan(input int idx, input logic val);
    @(posedge ref_clk);
    channel_pins[idx] <= val;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

/* File: verification/tb_top.sv */
/*
  self-checking bench for the remote ttl control block: register port tasks,
  pin stimulus through the user equipment model.
  assumes the package and design files are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  // ************
  // signals
  // ************
  logic ref_clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic [7:0] channel_out_n;
  logic [7:0] relay_drive;
  logic [11:0] pins;
  logic [7:0] chan_pins;
  wire [6:0] st;
  logic log_clear_pulse;
  logic keypad_ignore;
  logic panel_ignore;
  int miscompares;
  int check_count;
  int pulses;

  // free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  rtcio_user_equip UEQ (.ref_clk(ref_clk), .remote_pins(pins), .channel_pins(chan_pins));

  rtcio_top DUT (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .gauge_one_emission_request(pins[rtcio_pkg::RI_IG1]),
    .gauge_two_emission_request(pins[rtcio_pkg::RI_IG2]),
    .degas_request(pins[rtcio_pkg::RI_DEGAS]),
    .emission_lockout(pins[rtcio_pkg::RI_LOCK]),
    .gauge_keypad_disable(pins[rtcio_pkg::RI_KEY]),
    .pirani_one_power_input(pins[rtcio_pkg::RI_PG1]),
    .pirani_two_power_input(pins[rtcio_pkg::RI_PG2]),
    .log_clear_request(pins[rtcio_pkg::RI_LOG]),
    .remote_gauge_enable(pins[rtcio_pkg::RI_REN]),
    .filament_one_select(pins[rtcio_pkg::RI_FIL1]),
    .filament_two_select(pins[rtcio_pkg::RI_FIL2]),
    .panel_disable_n(pins[rtcio_pkg::RI_PANEL]),
    .channel_in(chan_pins), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .channel_out_n(channel_out_n),
    .relay_drive(relay_drive), .gauge_one_emission_on(st[0]),
    .gauge_two_emission_on(st[1]), .degas_on(st[2]), .filament_one_on(st[3]),
    .filament_two_on(st[4]), .pirani_one_on(st[5]), .pirani_two_on(st[6]),
    .log_clear_pulse(log_clear_pulse), .keypad_ignore(keypad_ignore),
    .panel_ignore(panel_ignore)
  );

  // pulse counter, so a stretched or repeated pulse shows up
  always @(posedge ref_clk)
  begin
    if (log_clear_pulse === 1'b1)
      pulses++;
  end

  // ************
  // tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200_000;
    miscompares++;
    wrap_up();
  end

  // ************
  // tests
  // ************
  initial
  begin : main
    int idx[7];
    logic [6:0] on_fall;
    logic [6:0] exp;
    idx = '{rtcio_pkg::RI_IG1, rtcio_pkg::RI_IG2, rtcio_pkg::RI_DEGAS, rtcio_pkg::RI_FIL1,
      rtcio_pkg::RI_FIL2, rtcio_pkg::RI_PG1, rtcio_pkg::RI_PG2};
    on_fall = 7'h1F;
    exp = 7'h60;
    rst_n = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(32'(channel_out_n), 32'h0000_00FF);
    chk(32'(relay_drive), 32'h0000_0000);
    chk(32'(st), 32'(exp));
    rd_chk(8'h0C, 32'h0000_0FFF);
    rd_chk(8'h20, 32'h0000_0000);
    UEQ.drive_remote(rtcio_pkg::RI_REN, 1'b0);
    // every edge input: falling then rising
    for (int i = 0; i < 7; i++)
    begin
      UEQ.drive_remote(idx[i], 1'b0);
      exp[i] = on_fall[i];
      chk(32'(st), 32'(exp));
      UEQ.drive_remote(idx[i], 1'b1);
      exp[i] = ~on_fall[i];
      chk(32'(st), 32'(exp));
    end
    UEQ.drive_remote(rtcio_pkg::RI_LOG, 1'b0);
    chk(32'(pulses), 32'h0000_0001);
    UEQ.drive_remote(rtcio_pkg::RI_LOG, 1'b1);
    chk(32'(pulses), 32'h0000_0001);
    // lockout kills emission and blocks a new request
    UEQ.drive_remote(rtcio_pkg::RI_IG1, 1'b0);
    chk(32'(st), 32'h0000_0061);
    UEQ.drive_remote(rtcio_pkg::RI_LOCK, 1'b0);
    chk(32'(st), 32'h0000_0060);
    UEQ.drive_remote(rtcio_pkg::RI_IG2, 1'b0);
    chk(32'(st), 32'h0000_0060);
    UEQ.drive_remote(rtcio_pkg::RI_LOCK, 1'b1);
    UEQ.drive_remote(rtcio_pkg::RI_IG1, 1'b1);
    UEQ.drive_remote(rtcio_pkg::RI_IG2, 1'b1);
    // remote enable high: requests are dropped
    UEQ.drive_remote(rtcio_pkg::RI_REN, 1'b1);
    for (int i = 0; i < 5; i++)
      UEQ.drive_remote(idx[i], 1'b0);
    chk(32'(st), 32'h0000_0060);
    UEQ.drive_remote(rtcio_pkg::RI_KEY, 1'b0);
    chk(32'(keypad_ignore), 32'h0000_0001);
    UEQ.drive_remote(rtcio_pkg::RI_PANEL, 1'b0);
    chk(32'(panel_ignore), 32'h0000_0001);
    UEQ.drive_remote(rtcio_pkg::RI_KEY, 1'b1);
    UEQ.drive_remote(rtcio_pkg::RI_PANEL, 1'b1);
    chk(32'({keypad_ignore, panel_ignore}), 32'h0000_0000);
    // manual channels, then automatic with both polarities
    wr(8'h00, 32'h0000_01A5);
    chk(32'(channel_out_n), 32'h0000_005A);
    chk(32'(relay_drive), 32'h0000_00A5);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0003);
    wr(8'h08, 32'h0000_0002);
    chk(32'(channel_out_n), 32'h0000_00FD);
    UEQ.drive_chan(0, 1'b0);
    UEQ.drive_chan(1, 1'b0);
    chk(32'(channel_out_n), 32'h0000_00FE);
    chk(32'(relay_drive), 32'h0000_0001);
    rd_chk(8'h08, 32'h0000_0002);
    rd_chk(8'h10, 32'h0000_0260);
    rd_chk(8'h14, 32'h0000_FC01);
    // mid-run reset: outputs drop back at once, held pin levels become history
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'(channel_out_n), 32'h0000_00FF);
    chk(32'(relay_drive), 32'h0000_0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(32'(st), 32'h0000_0060);
    chk(32'(channel_out_n), 32'h0000_00FF);
    rd_chk(8'h04, 32'h0000_0000);
    wrap_up();
  end
endmodule
